// File: rtl/orf_consts.vh
`ifndef ORF_CONSTS_VH
`define ORF_CONSTS_VH

// Operand sizes
`define ORF_SZ_BYTE 2'h0
`define ORF_SZ_WORD 2'h1
`define ORF_SZ_LONG 2'h2

// Status word layout
`define ORF_PSW_T1 15
`define ORF_PSW_T0 14
`define ORF_PSW_S 13
`define ORF_PSW_IHI 10
`define ORF_PSW_ILO 8
`define ORF_PSW_DEF 16'hE71F
`define ORF_CCR_DEF 8'h1F
`define ORF_PSW_RST 16'h2700

// Control register selects
`define ORF_CTL_PSW 2'h0
`define ORF_CTL_CCR 2'h1
`define ORF_CTL_SRCSP 2'h2
`define ORF_CTL_DSTSP 2'h3
`define ORF_SPACE_W 3

// Operand address field modes
`define ORF_MODE_DREG 3'h0
`define ORF_MODE_AREG 3'h1
`define ORF_MODE_AIND 3'h2
`define ORF_MODE_APOST 3'h3
`define ORF_MODE_APRE 3'h4
`define ORF_MODE_ADISP 3'h5
`define ORF_MODE_AIDX 3'h6
`define ORF_MODE_SPEC 3'h7

// Submodes of the special mode
`define ORF_SUB_ABSW 3'h0
`define ORF_SUB_ABSL 3'h1
`define ORF_SUB_PCDISP 3'h2
`define ORF_SUB_PCIDX 3'h3
`define ORF_SUB_IMM 3'h4

// Decimal operations
`define ORF_DEC_ADD 2'h0
`define ORF_DEC_SUB 2'h1
`define ORF_DEC_NEG 2'h2

// Big-endian byte enables, bit 3 is the byte at the lowest address
`define ORF_BE_BYTE 4'h8
`define ORF_BE_WORD 4'hC
`define ORF_BE_LONG 4'hF

`endif

// File: rtl/orf_ea_decode.v
`timescale 1ns/1ps
`include "orf_consts.vh"

module orf_ea_decode (
  // Operand address field and size
  input wire [5:0] eaField,
  input wire [1:0] eaSize,
  // Decoded view
  output reg [2:0] eaMode,
  output reg [2:0] eaRegSel,
  output reg eaUsesReg,
  output reg eaProgRef,
  output reg [1:0] eaExtWords,
  output reg eaBad
);

  always @* begin
    eaMode = eaField[5:3];
    eaRegSel = eaField[2:0];
    eaUsesReg = 1'b1;
    eaProgRef = 1'b0;
    eaExtWords = 2'h0;
    eaBad = 1'b0;
    case (eaField[5:3])
      `ORF_MODE_ADISP: begin
        eaExtWords = 2'h1;
      end
      `ORF_MODE_AIDX: begin
        eaExtWords = 2'h1;
      end
      `ORF_MODE_SPEC: begin
        eaUsesReg = 1'b0;
        case (eaField[2:0])
          `ORF_SUB_ABSW: eaExtWords = 2'h1;
          `ORF_SUB_ABSL: eaExtWords = 2'h2;
          `ORF_SUB_PCDISP: begin
            eaExtWords = 2'h1;
            eaProgRef = 1'b1;
          end
          `ORF_SUB_PCIDX: begin
            eaExtWords = 2'h1;
            eaProgRef = 1'b1;
          end
          `ORF_SUB_IMM: begin
            eaExtWords = (eaSize == `ORF_SZ_LONG) ? 2'h2 : 2'h1;
            eaProgRef = 1'b1;
          end
          default: eaBad = 1'b1;
        endcase
      end
      default: eaExtWords = 2'h0;
    endcase
  end

endmodule // orf_ea_decode

// File: rtl/orf_core.v
// Behaviour
// - Data register byte uses bits 7:0, word 15:0, long all 32 bits
// - Byte or word access leaves upper data register bits unread and unchanged
// - Bit 0 is the least significant, bit 31 the most significant
// - A 64-bit result may go to any two data registers
// - Decimal bytes hold two packed 4-bit digits
// - Address registers and stack pointers refuse byte size
// - Address register source gives low 16 bits or all 32 bits
// - Address register destination is always written in full
// - Word source to address register is sign-extended to 32 bits
// - Control registers need supervisor level, except the condition byte
// - Status word is 16 bits, 11 defined, undefined bits read zero
// - Status and condition byte are word access; upper byte zero and ignored
// - Space select registers keep bits 2:0 only, long-word access
// - Memory is big-endian; most significant byte at the lowest address
// - Word, long and instruction data lie on even addresses
// - Operand address field splits into 3-bit mode and register
// - Mode 7 uses the register field as a submode
// - Modes needing more fetch extension words after the operation word
// - Operation and extension word fetches are program-space references
// - Operand reads are data space except immediate and program-relative
// - Every operand write is a data-space reference
// - Address register seven is user or supervisor stack pointer by privilege
// - Status word holds interrupt mask, two trace bits and privilege bit
`timescale 1ns/1ps
`include "orf_consts.vh"

module orf_core (
  // Clock and reset
  input wire clk_sys,
  input wire resetn,
  // Register read port
  input wire rdEn,
  input wire [3:0] rdSel,
  input wire [1:0] rdSize,
  output reg [31:0] rdData_r,
  output reg [31:0] rdDataSext_r,
  // Register write port
  input wire wrEn,
  input wire [3:0] wrSel,
  input wire [1:0] wrSize,
  input wire [31:0] wrData,
  // Second data register write port for 64-bit results
  input wire wrHiEn,
  input wire [2:0] wrHiSel,
  input wire [31:0] wrHiData,
  output reg sizeFault_r,
  // Condition flag update from the execution unit
  input wire ccrUpdEn,
  input wire [4:0] ccrIn,
  // Control register port
  input wire ctlEn,
  input wire ctlWr,
  input wire [1:0] ctlSel,
  input wire [1:0] ctlSize,
  input wire [31:0] ctlWdata,
  output reg [31:0] ctlRdata_r,
  output reg ctlFault_r,
  output reg [15:0] processorStatusWord_r,
  output reg [2:0] sourceSpaceSelect_r,
  output reg [2:0] destinationSpaceSelect_r,
  // Operand address field decode
  input wire decEn,
  input wire [5:0] operandAddressField,
  input wire [1:0] decSize,
  output reg [2:0] eaMode_r,
  output reg [2:0] eaRegSel_r,
  output reg eaUsesReg_r,
  output reg eaProgRef_r,
  output reg [1:0] eaExtWords_r,
  output reg eaBad_r,
  // Memory reference request
  input wire memReq,
  input wire memFetch,
  input wire memWr,
  input wire [1:0] memSize,
  input wire [31:0] memAddr,
  input wire [31:0] memWdata,
  output reg busReq_r,
  output reg busWr_r,
  output reg busProgSpace_r,
  output reg busSuper_r,
  output reg [31:0] busAddr_r,
  output reg [3:0] busBe_r,
  output reg [31:0] busData_r,
  output reg addrError_r,
  // Decimal byte arithmetic
  input wire bcdEn,
  input wire [1:0] bcdOp,
  input wire [7:0] bcdDst,
  input wire [7:0] bcdSrc,
  input wire bcdExtend,
  output reg [7:0] bcdResult_r,
  output reg bcdCarry_r
);

  reg [31:0] dataReg [0:7];
  reg [31:0] addrReg [0:6];
  reg [31:0] userStackPointer_r, supervisorStackPointer_r;
  reg [31:0] rdRaw, rdVal, wrAddrVal;
  reg rdBad, wrBad, ctlBad;
  reg [31:0] ctlVal;
  reg [4:0] loSum, hiSum;
  reg [3:0] loDig, hiDig;
  reg loCarry, hiCarry;
  reg [7:0] bcdA;
  wire superMode;
  wire [2:0] eaMode, eaRegSel;
  wire eaUsesReg, eaProgRef, eaBad;
  wire [1:0] eaExtWords;
  integer i;

  assign superMode = processorStatusWord_r[`ORF_PSW_S];

  orf_ea_decode uDecode (
    .eaField(operandAddressField),
    .eaSize(decSize),
    .eaMode(eaMode),
    .eaRegSel(eaRegSel),
    .eaUsesReg(eaUsesReg),
    .eaProgRef(eaProgRef),
    .eaExtWords(eaExtWords),
    .eaBad(eaBad)
  );

  // Register read selection and sizing
  always @* begin
    rdBad = 1'b0;
    if (!rdSel[3]) begin
      rdRaw = dataReg[rdSel[2:0]];
    end else if (rdSel[2:0] == 3'h7) begin
      rdRaw = superMode ? supervisorStackPointer_r : userStackPointer_r;
    end else begin
      rdRaw = addrReg[rdSel[2:0]];
    end
    case (rdSize)
      `ORF_SZ_BYTE: begin
        rdVal = {24'h000000, rdRaw[7:0]};
        rdBad = rdSel[3];
      end
      `ORF_SZ_WORD: rdVal = {16'h0000, rdRaw[15:0]};
      `ORF_SZ_LONG: rdVal = rdRaw;
      default: begin
        rdVal = 32'h00000000;
        rdBad = 1'b1;
      end
    endcase
  end

  // Write value for address registers and size check
  always @* begin
    wrBad = 1'b0;
    case (wrSize)
      `ORF_SZ_WORD: wrAddrVal = {{16{wrData[15]}}, wrData[15:0]};
      `ORF_SZ_LONG: wrAddrVal = wrData;
      default: begin
        wrAddrVal = wrData;
        wrBad = wrSel[3] || (wrSize != `ORF_SZ_BYTE);
      end
    endcase
  end

  // Control register access checks and read value
  always @* begin
    ctlBad = 1'b0;
    ctlVal = 32'h00000000;
    case (ctlSel)
      `ORF_CTL_PSW: begin
        ctlBad = !superMode || (ctlSize != `ORF_SZ_WORD);
        ctlVal = {16'h0000, processorStatusWord_r & `ORF_PSW_DEF};
      end
      `ORF_CTL_CCR: begin
        ctlBad = (ctlSize != `ORF_SZ_WORD);
        ctlVal = {24'h000000, processorStatusWord_r[7:0] & `ORF_CCR_DEF};
      end
      `ORF_CTL_SRCSP: begin
        ctlBad = !superMode || (ctlSize != `ORF_SZ_LONG);
        ctlVal = {29'h0000000, sourceSpaceSelect_r};
      end
      `ORF_CTL_DSTSP: begin
        ctlBad = !superMode || (ctlSize != `ORF_SZ_LONG);
        ctlVal = {29'h0000000, destinationSpaceSelect_r};
      end
      default: ctlBad = 1'b1;
    endcase
  end

  // Packed decimal digit arithmetic
  always @* begin
    bcdA = (bcdOp == `ORF_DEC_NEG) ? 8'h00 : bcdDst;
    loDig = 4'h0;
    hiDig = 4'h0;
    if (bcdOp == `ORF_DEC_ADD) begin
      loSum = {1'b0, bcdA[3:0]} + {1'b0, bcdSrc[3:0]} + {4'h0, bcdExtend};
      loCarry = (loSum > 5'h09);
      loDig = loCarry ? loSum[3:0] + 4'h6 : loSum[3:0];
      hiSum = {1'b0, bcdA[7:4]} + {1'b0, bcdSrc[7:4]} + {4'h0, loCarry};
      hiCarry = (hiSum > 5'h09);
      hiDig = hiCarry ? hiSum[3:0] + 4'h6 : hiSum[3:0];
    end else begin
      loSum = {1'b0, bcdA[3:0]} - {1'b0, bcdSrc[3:0]} - {4'h0, bcdExtend};
      loCarry = loSum[4];
      loDig = loCarry ? loSum[3:0] - 4'h6 : loSum[3:0];
      hiSum = {1'b0, bcdA[7:4]} - {1'b0, bcdSrc[7:4]} - {4'h0, loCarry};
      hiCarry = hiSum[4];
      hiDig = hiCarry ? hiSum[3:0] - 4'h6 : hiSum[3:0];
    end
  end

  // Register file storage
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (i = 0; i < 8; i = i + 1) begin
        dataReg[i] <= 32'h00000000;
      end
      for (i = 0; i < 7; i = i + 1) begin
        addrReg[i] <= 32'h00000000;
      end
      userStackPointer_r <= 32'h00000000;
      supervisorStackPointer_r <= 32'h00000000;
    end else begin
      if (wrHiEn) begin
        dataReg[wrHiSel] <= wrHiData;
      end
      if (wrEn && !wrBad) begin
        if (!wrSel[3]) begin
          case (wrSize)
            `ORF_SZ_BYTE: dataReg[wrSel[2:0]][7:0] <= wrData[7:0];
            `ORF_SZ_WORD: dataReg[wrSel[2:0]][15:0] <= wrData[15:0];
            default: dataReg[wrSel[2:0]] <= wrData;
          endcase
        end else if (wrSel[2:0] == 3'h7) begin
          if (superMode) begin
            supervisorStackPointer_r <= wrAddrVal;
          end else begin
            userStackPointer_r <= wrAddrVal;
          end
        end else begin
          addrReg[wrSel[2:0]] <= wrAddrVal;
        end
      end
    end
  end

  // Read port, control registers and status word
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdData_r <= 32'h00000000;
      rdDataSext_r <= 32'h00000000;
      sizeFault_r <= 1'b0;
      ctlRdata_r <= 32'h00000000;
      ctlFault_r <= 1'b0;
      processorStatusWord_r <= `ORF_PSW_RST;
      sourceSpaceSelect_r <= 3'h0;
      destinationSpaceSelect_r <= 3'h0;
    end else begin
      if (rdEn && !rdBad) begin
        rdData_r <= rdVal;
        rdDataSext_r <= (rdSize == `ORF_SZ_WORD) ? {{16{rdRaw[15]}}, rdRaw[15:0]} : rdVal;
      end
      sizeFault_r <= (rdEn && rdBad) || (wrEn && wrBad);
      ctlFault_r <= ctlEn && ctlBad;
      if (ctlEn && !ctlWr && !ctlBad) begin
        ctlRdata_r <= ctlVal;
      end
      if (ccrUpdEn) begin
        processorStatusWord_r[4:0] <= ccrIn;
      end
      if (ctlEn && ctlWr && !ctlBad) begin
        case (ctlSel)
          `ORF_CTL_PSW: processorStatusWord_r <= ctlWdata[15:0] & `ORF_PSW_DEF;
          `ORF_CTL_CCR: processorStatusWord_r[7:0] <= ctlWdata[7:0] & `ORF_CCR_DEF;
          `ORF_CTL_SRCSP: sourceSpaceSelect_r <= ctlWdata[`ORF_SPACE_W-1:0];
          `ORF_CTL_DSTSP: destinationSpaceSelect_r <= ctlWdata[`ORF_SPACE_W-1:0];
          default: sourceSpaceSelect_r <= sourceSpaceSelect_r;
        endcase
      end
    end
  end

  // Decode results, memory references and decimal results
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      eaMode_r <= 3'h0;
      eaRegSel_r <= 3'h0;
      eaUsesReg_r <= 1'b0;
      eaProgRef_r <= 1'b0;
      eaExtWords_r <= 2'h0;
      eaBad_r <= 1'b0;
      busReq_r <= 1'b0;
      busWr_r <= 1'b0;
      busProgSpace_r <= 1'b0;
      busSuper_r <= 1'b0;
      busAddr_r <= 32'h00000000;
      busBe_r <= 4'h0;
      busData_r <= 32'h00000000;
      addrError_r <= 1'b0;
      bcdResult_r <= 8'h00;
      bcdCarry_r <= 1'b0;
    end else begin
      if (decEn) begin
        eaMode_r <= eaMode;
        eaRegSel_r <= eaRegSel;
        eaUsesReg_r <= eaUsesReg;
        eaProgRef_r <= eaProgRef;
        eaExtWords_r <= eaExtWords;
        eaBad_r <= eaBad;
      end
      addrError_r <= memReq && (memFetch || memSize != `ORF_SZ_BYTE) && memAddr[0];
      busReq_r <= memReq && !((memFetch || memSize != `ORF_SZ_BYTE) && memAddr[0]);
      if (memReq) begin
        busWr_r <= memWr && !memFetch;
        busProgSpace_r <= memFetch || (!memWr && eaProgRef_r);
        busSuper_r <= superMode;
        busAddr_r <= memAddr;
        case (memFetch ? `ORF_SZ_WORD : memSize)
          `ORF_SZ_BYTE: begin
            busBe_r <= `ORF_BE_BYTE;
            busData_r <= {memWdata[7:0], 24'h000000};
          end
          `ORF_SZ_WORD: begin
            busBe_r <= `ORF_BE_WORD;
            busData_r <= {memWdata[15:0], 16'h0000};
          end
          default: begin
            busBe_r <= `ORF_BE_LONG;
            busData_r <= memWdata;
          end
        endcase
      end
      if (bcdEn) begin
        bcdResult_r <= {hiDig, loDig};
        bcdCarry_r <= hiCarry;
      end
    end
  end

endmodule // orf_core

// File: dv/orf_core_asserts.sv
`timescale 1ns/1ps
module orf_core_asserts (
  // Clock and reset
  input wire clk_sys,
  input wire resetn,
  // Register ports
  input wire rdEn,
  input wire [3:0] rdSel,
  input wire [1:0] rdSize,
  input wire [31:0] rdData_r,
  input wire wrEn,
  input wire [3:0] wrSel,
  input wire [1:0] wrSize,
  input wire sizeFault_r,
  input wire wrHiEn,
  // Control and decode
  input wire ctlEn,
  input wire [1:0] ctlSel,
  input wire ctlFault_r,
  input wire [15:0] processorStatusWord_r,
  input wire decEn,
  input wire [5:0] operandAddressField,
  input wire [2:0] eaMode_r,
  input wire [2:0] eaRegSel_r,
  // Memory side
  input wire memReq,
  input wire memFetch,
  input wire memWr,
  input wire [1:0] memSize,
  input wire [31:0] memAddr,
  input wire busReq_r,
  input wire busProgSpace_r,
  input wire addrError_r
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  byte_read_low_a: assert property (rdEn && rdSel < 4'h8 && rdSize == 2'h0 |=> rdData_r[31:8] == 24'h0)
    else $error("byte read upper bits not zero");
  addr_byte_refuse_a: assert property (wrEn && wrSel[3] && wrSize == 2'h0 |=> sizeFault_r)
    else $error("byte write to address register accepted");
  user_ctl_refuse_a: assert property (ctlEn && !processorStatusWord_r[13] && ctlSel != 2'h1 |=> ctlFault_r)
    else $error("user control access not refused");
  psw_undef_zero_a: assert property ((processorStatusWord_r & 16'h18E0) == 16'h0)
    else $error("undefined status bit set");
  ea_split_a: assert property (decEn |=> {eaMode_r, eaRegSel_r} == $past(operandAddressField))
    else $error("operand field split wrong");
  odd_abort_a: assert property (memReq && memAddr[0] && (memSize != 2'h0 || memFetch) |=> addrError_r && !busReq_r)
    else $error("odd access not aborted");
  write_data_space_a: assert property (memReq && memWr && !memAddr[0] |=> busReq_r && !busProgSpace_r)
    else $error("write not in data space");
  fetch_prog_space_a: assert property (memReq && memFetch && !memAddr[0] |=> busReq_r && busProgSpace_r)
    else $error("fetch not in program space");
  cover property (wrEn && wrHiEn);
  cover property (addrError_r);
  cover property (ctlFault_r);
endmodule // orf_core_asserts

bind orf_core orf_core_asserts i_orf_core_asserts (.clk_sys, .resetn, .rdEn, .rdSel, .rdSize, .rdData_r, .wrEn,
  .wrSel, .wrSize, .sizeFault_r, .wrHiEn, .ctlEn, .ctlSel, .ctlFault_r, .processorStatusWord_r, .decEn,
  .operandAddressField, .eaMode_r, .eaRegSel_r, .memReq, .memFetch, .memWr, .memSize, .memAddr, .busReq_r,
  .busProgSpace_r, .addrError_r);

// File: dv/orf_mem_model.sv
`timescale 1ns/1ps
module orf_mem_model (
  // Bus from the core
  input wire clk_sys,
  input wire busReq_r,
  input wire busWr_r,
  input wire busProgSpace_r,
  input wire [31:0] busAddr_r,
  input wire [3:0] busBe_r,
  input wire [31:0] busData_r
);
  logic [7:0] dataMem [0:255];
  // Lane 3 is the byte at the lowest address; only data space takes writes
  always @(posedge clk_sys) begin
    if (busReq_r && busWr_r && !busProgSpace_r) begin
      for (int i = 0; i < 4; i++) begin
        if (busBe_r[3 - i]) begin
          dataMem[busAddr_r[7:0] + i] <= busData_r[31 - 8 * i -: 8];
        end
      end
    end
  end
endmodule // orf_mem_model

// File: dv/tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin n_fail++; $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module tb;
  typedef struct {logic we; logic [3:0] ws; logic [1:0] wz; logic [31:0] wd; logic [3:0] rs; logic [1:0] rz;
    logic [31:0] ex;} orf_row_t;
  int n_fail = 0;
  int checks = 0;
  logic clk_sys = 1'h0;
  logic resetn = 1'h0;
  logic rdEn, wrEn, wrHiEn, ccrUpdEn, ctlEn, ctlWr, decEn, memReq, memFetch, memWr, bcdEn, bcdExtend;
  logic [1:0] rdSize, wrSize, ctlSel, ctlSize, decSize, memSize, bcdOp, eaExtWords_r;
  logic [3:0] rdSel, wrSel, busBe_r;
  logic [2:0] wrHiSel, sourceSpaceSelect_r, destinationSpaceSelect_r, eaMode_r, eaRegSel_r;
  logic [4:0] ccrIn;
  logic [5:0] operandAddressField;
  logic [7:0] bcdDst, bcdSrc, bcdResult_r;
  logic [15:0] processorStatusWord_r;
  logic [31:0] wrData, wrHiData, ctlWdata, memAddr, memWdata, rdData_r, rdDataSext_r, ctlRdata_r, busAddr_r, busData_r;
  logic sizeFault_r, ctlFault_r, eaUsesReg_r, eaProgRef_r, busReq_r, busWr_r, busProgSpace_r, addrError_r, bcdCarry_r;
  logic eaBad_r, busSuper_r;
  orf_row_t rows [6] = '{'{1'h1, 4'h0, 2'h2, 32'h12345678, 4'h0, 2'h2, 32'h12345678},
    '{1'h1, 4'h0, 2'h0, 32'hAAAAAA9C, 4'h0, 2'h2, 32'h1234569C}, '{1'h1, 4'h0, 2'h1, 32'h0000BEEF, 4'h0, 2'h2, 32'h1234BEEF},
    '{1'h0, 4'h0, 2'h0, 32'h0, 4'h0, 2'h0, 32'h000000EF}, '{1'h1, 4'h8, 2'h1, 32'h00008001, 4'h8, 2'h2, 32'hFFFF8001},
    '{1'h0, 4'h0, 2'h0, 32'h0, 4'h8, 2'h1, 32'h00008001}};
  logic [5:0] fld [5] = '{6'h3C, 6'h3A, 6'h38, 6'h13, 6'h3D};
  logic [10:0] dex [5] = '{11'h1BC, 11'h17A, 11'h078, 11'h213, 11'h43D};
  logic [1:0] bop [5] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h0};
  logic [7:0] bd [5] = '{8'h19, 8'h99, 8'h47, 8'h00, 8'h19};
  logic [7:0] bs [5] = '{8'h28, 8'h01, 8'h28, 8'h01, 8'h28};
  logic bx [5] = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h1};
  logic [8:0] bex [5] = '{9'h047, 9'h100, 9'h019, 9'h199, 9'h048};
  orf_core i_orf_core (.clk_sys, .resetn, .rdEn, .rdSel, .rdSize, .rdData_r, .rdDataSext_r, .wrEn, .wrSel, .wrSize,
    .wrData, .wrHiEn, .wrHiSel, .wrHiData, .sizeFault_r, .ccrUpdEn, .ccrIn, .ctlEn, .ctlWr, .ctlSel, .ctlSize,
    .ctlWdata, .ctlRdata_r, .ctlFault_r, .processorStatusWord_r, .sourceSpaceSelect_r, .destinationSpaceSelect_r,
    .decEn, .operandAddressField, .decSize, .eaMode_r, .eaRegSel_r, .eaUsesReg_r, .eaProgRef_r, .eaExtWords_r,
    .eaBad_r, .memReq, .memFetch, .memWr, .memSize, .memAddr, .memWdata, .busReq_r, .busWr_r, .busProgSpace_r,
    .busSuper_r, .busAddr_r, .busBe_r, .busData_r, .addrError_r, .bcdEn, .bcdOp, .bcdDst, .bcdSrc, .bcdExtend,
    .bcdResult_r, .bcdCarry_r);
  orf_mem_model i_orf_mem_model (.clk_sys, .busReq_r, .busWr_r, .busProgSpace_r, .busAddr_r, .busBe_r, .busData_r);
  always #2.5 clk_sys = ~clk_sys;
  task automatic idle;
    {rdEn, wrEn, wrHiEn, ccrUpdEn, ctlEn, ctlWr, decEn, memReq, memFetch, memWr, bcdEn, bcdExtend, rdSize, wrSize,
      ctlSel, ctlSize, decSize, memSize, bcdOp, rdSel, wrSel, wrHiSel, ccrIn, operandAddressField, bcdDst, bcdSrc,
      wrData, wrHiData, ctlWdata, memAddr, memWdata} = '0;
  endtask
  // Request stands one edge, outputs are read at the following falling edge
  task automatic run;
    @(negedge clk_sys);
    idle();
  endtask
  task automatic wr(input logic [3:0] s, input logic [1:0] z, input logic [31:0] d);
    @(negedge clk_sys);
    {wrEn, wrSel, wrSize, wrData} = {1'h1, s, z, d};
    run();
  endtask
  task automatic rd(input logic [3:0] s, input logic [1:0] z);
    @(negedge clk_sys);
    {rdEn, rdSel, rdSize} = {1'h1, s, z};
    run();
  endtask
  task automatic ctl(input logic w, input logic [1:0] s, input logic [1:0] z, input logic [31:0] d);
    @(negedge clk_sys);
    {ctlEn, ctlWr, ctlSel, ctlSize, ctlWdata} = {1'h1, w, s, z, d};
    run();
  endtask
  task automatic mem(input logic f, input logic w, input logic [1:0] z, input logic [31:0] a);
    @(negedge clk_sys);
    {memReq, memFetch, memWr, memSize, memAddr, memWdata} = {1'h1, f, w, z, a, 32'h11223344};
    run();
  endtask
  task automatic finish_test;
    $display("Comparisons %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #20000;
    n_fail++;
    finish_test();
  end
  initial begin
    idle();
    repeat (10) @(negedge clk_sys);
    resetn = 1'h1;
    `CHK("pswReset", 16'h2700, processorStatusWord_r)
    foreach (rows[i]) begin
      if (rows[i].we) begin
        wr(rows[i].ws, rows[i].wz, rows[i].wd);
      end
      rd(rows[i].rs, rows[i].rz);
      `CHK("rdData", rows[i].ex, rdData_r)
    end
    `CHK("rdSext", 32'hFFFF8001, rdDataSext_r)
    wr(4'h8, 2'h0, 32'h00000011);
    `CHK("sizeFault", 1'h1, sizeFault_r)
    rd(4'h8, 2'h2);
    `CHK("a0Kept", 32'hFFFF8001, rdData_r)
    @(negedge clk_sys);
    {wrEn, wrSel, wrSize, wrData, wrHiEn, wrHiSel, wrHiData} = {1'h1, 4'h5, 2'h2, 32'h89ABCDEF, 1'h1, 3'h2, 32'h01234567};
    run();
    rd(4'h5, 2'h2);
    `CHK("quadLo", 32'h89ABCDEF, rdData_r)
    rd(4'h2, 2'h2);
    `CHK("quadHi", 32'h01234567, rdData_r)
    ctl(1'h1, 2'h0, 2'h1, 32'h0000FFFF);
    `CHK("pswMask", 16'hE71F, processorStatusWord_r)
    ctl(1'h1, 2'h2, 2'h2, 32'hFFFFFFFF);
    ctl(1'h0, 2'h2, 2'h2, 32'h0);
    `CHK("spaceRd", 32'h00000007, ctlRdata_r)
    ctl(1'h1, 2'h2, 2'h1, 32'h0);
    `CHK("spaceSize", 4'hF, {ctlFault_r, sourceSpaceSelect_r})
    ctl(1'h1, 2'h3, 2'h2, 32'hFFFFFFFA);
    `CHK("dstSpace", 3'h2, destinationSpaceSelect_r)
    wr(4'hF, 2'h2, 32'h00000400);
    ctl(1'h1, 2'h0, 2'h1, 32'h0);
    rd(4'hF, 2'h2);
    `CHK("userStack", 32'h0, rdData_r)
    ctl(1'h1, 2'h0, 2'h1, 32'h00002700);
    `CHK("userFault", 1'h1, ctlFault_r)
    ctl(1'h1, 2'h1, 2'h1, 32'h0000FFFF);
    `CHK("ccrWrite", 16'h001F, processorStatusWord_r)
    ctl(1'h0, 2'h1, 2'h1, 32'h0);
    `CHK("ccrRead", 32'h0000001F, ctlRdata_r)
    foreach (fld[i]) begin
      @(negedge clk_sys);
      {decEn, operandAddressField, decSize} = {1'h1, fld[i], 2'h2};
      run();
      `CHK("eaDecode", dex[i], {eaBad_r, eaUsesReg_r, eaProgRef_r, eaExtWords_r, eaMode_r, eaRegSel_r})
    end
    foreach (bop[i]) begin
      @(negedge clk_sys);
      {bcdEn, bcdOp, bcdDst, bcdSrc, bcdExtend} = {1'h1, bop[i], bd[i], bs[i], bx[i]};
      run();
      `CHK("bcd", bex[i], {bcdCarry_r, bcdResult_r})
    end
    mem(1'h0, 1'h1, 2'h2, 32'h00000010);
    `CHK("wrSpace", 2'h2, {busReq_r, busProgSpace_r})
    @(negedge clk_sys);
    `CHK("bigEndian", 32'h11223344, {i_orf_mem_model.dataMem[16], i_orf_mem_model.dataMem[17],
      i_orf_mem_model.dataMem[18], i_orf_mem_model.dataMem[19]})
    mem(1'h0, 1'h1, 2'h1, 32'h00000021);
    `CHK("oddAbort", 2'h2, {addrError_r, busReq_r})
    mem(1'h1, 1'h0, 2'h1, 32'h00000020);
    `CHK("fetchSpace", 2'h3, {busReq_r, busProgSpace_r})
    mem(1'h0, 1'h0, 2'h1, 32'h00000030);
    `CHK("readSpace", 2'h2, {busReq_r, busProgSpace_r})
    @(negedge clk_sys);
    {decEn, operandAddressField, decSize} = {1'h1, 6'h3B, 2'h1};
    run();
    mem(1'h0, 1'h0, 2'h1, 32'h00000032);
    `CHK("pcRelSpace", 2'h3, {busReq_r, busProgSpace_r})
    resetn = 1'h0;
    repeat (2) @(negedge clk_sys);
    resetn = 1'h1;
    `CHK("pswReset2", 16'h2700, processorStatusWord_r)
    mem(1'h1, 1'h0, 2'h1, 32'h00000040);
    `CHK("superFetch", 3'h7, {busReq_r, busProgSpace_r, busSuper_r})
    finish_test();
  end
endmodule // tb
